//--- design/tws_defines.vh
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define TWS_OFS_CTRL      8'h00
`define TWS_OFS_STATUS    8'h04
`define TWS_OFS_DATA      8'h08
`define TWS_OFS_OWNADDR   8'h0c
// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define TWS_CTL_FLAG      7
`define TWS_CTL_ACKEN     6
`define TWS_CTL_START     5
`define TWS_CTL_STOP      4
`define TWS_CTL_ENABLE    2
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define TWS_RST_CTRL      8'h00
`define TWS_RST_OWNADDR   8'h00
`define TWS_RST_DATA      8'hff
`define TWS_RST_STATUS    8'hf8
// -----------------------------------------------------------------
// status codes, prescaler bits zero
// -----------------------------------------------------------------
`define TWS_ST_START      8'h08
`define TWS_ST_RSTART     8'h10
`define TWS_ST_MR_NACK    8'h58
`define TWS_ST_SR_OWN     8'h60
`define TWS_ST_SR_GCALL   8'h70
`define TWS_ST_OWN_READ   8'ha8
`define TWS_ST_ARB_READ   8'hb0
`define TWS_ST_TX_ACK     8'hb8
`define TWS_ST_TX_NACK    8'hc0
`define TWS_ST_LAST_ACK   8'hc8
`define TWS_ST_NONE       8'hf8
`define TWS_GCALL_ADDR    7'h00
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TWS_CLK_PERIOD_NS 4
`define TWS_GEN_HALF_NS   5000
`define TWS_GEN_HALF_CYC  ((`TWS_GEN_HALF_NS + `TWS_CLK_PERIOD_NS - 1) / `TWS_CLK_PERIOD_NS)
`endif

//--- design/tws_slave_tx.v
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "tws_defines.vh"
module tws_slave_tx (
   // clock and reset
   input  wire        core_clk,
   input  wire        reset_n,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // two-wire bus pins
   input  wire        scl_in,
   output wire        scl_out,
   output wire        scl_oe,
   input  wire        sda_in,
   output wire        sda_out,
   output wire        sda_oe,
   // rest of the unit
   input  wire        deep_sleep,
   input  wire        arb_lost,
   input  wire        mr_nack_done,
   input  wire [7:0]  mr_rx_byte,
   output wire        wake_req
);

   // -----------------------------------------------------------------
   // states
   // -----------------------------------------------------------------
   localparam [7:0] S_IDLE  = 8'h01;
   localparam [7:0] S_ADDR  = 8'h02;
   localparam [7:0] S_AACK  = 8'h04;
   localparam [7:0] S_TX    = 8'h08;
   localparam [7:0] S_MACK  = 8'h10;
   localparam [7:0] S_WAIT  = 8'h20;
   localparam [7:0] S_IGN   = 8'h40;
   localparam [7:0] S_MSTR  = 8'h80;

   localparam [2:0] G_IDLE  = 3'd0;
   localparam [2:0] G_PREP  = 3'd1;
   localparam [2:0] G_SCLHI = 3'd2;
   localparam [2:0] G_STOP  = 3'd3;
   localparam [2:0] G_START = 3'd4;

   localparam integer HALF_CYC = `TWS_GEN_HALF_CYC;
   localparam [15:0]  HALF     = HALF_CYC[15:0];

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   reg  [7:0]  ctrl;
   reg  [7:0]  own_slave_address;
   reg  [7:0]  data;
   reg  [7:0]  status;
   reg  [1:0]  presc;
   reg         wr_pend;
   reg  [7:0]  wr_addr;
   reg  [7:0]  state;
   reg  [2:0]  gphase;
   reg  [15:0] gcnt;
   reg         g_stop;
   reg         g_start;
   reg         gen_sda;
   reg         gen_scl;
   reg  [7:0]  shift;
   reg  [3:0]  bitcnt;
   reg         last_byte;
   reg         master_ack;
   reg         arb_pend;
   reg         sleep_match;
   reg         tx_bit_low;
   reg         ack_low;
   reg         scl_s1, scl_s2, scl_d;
   reg         sda_s1, sda_s2, sda_d;

   wire        interface_enable   = ctrl[`TWS_CTL_ENABLE];
   wire        acknowledge_enable = ctrl[`TWS_CTL_ACKEN];
   wire        serial_interrupt_flag = ctrl[`TWS_CTL_FLAG];
   wire [6:0]  own_address_field  = own_slave_address[7:1];
   wire        general_call_accept = own_slave_address[0];

   wire        scl_rise = scl_s2 & ~scl_d;
   wire        scl_fall = ~scl_s2 & scl_d;
   wire        bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire        bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

   wire        addr_ph  = hsel & hready & htrans[1];
   wire        wr_ctrl  = wr_pend & (wr_addr == `TWS_OFS_CTRL);
   wire        flag_clr = wr_ctrl & hwdata[`TWS_CTL_FLAG];

   // -----------------------------------------------------------------
   // address match
   // -----------------------------------------------------------------
   function match_addr;
      input [6:0] a;
      input [6:0] own;
      input       gc_ok;
      begin
         match_addr = (a == own) | (gc_ok & (a == `TWS_GCALL_ADDR));
      end
   endfunction

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!reset_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   // -----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // -----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @(posedge core_clk) begin
      if (!reset_n) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0000_0000;
      end else begin
         wr_pend <= addr_ph & hwrite;
         wr_addr <= haddr[7:0];
         if (addr_ph & ~hwrite) begin
            case (haddr[7:0])
               `TWS_OFS_CTRL:    hrdata <= {24'h000000, ctrl};
               // prescaler sits in the low bits
               `TWS_OFS_STATUS:  hrdata <= {24'h000000, status[7:3], 1'b0, presc};
               `TWS_OFS_DATA:    hrdata <= {24'h000000, data};
               `TWS_OFS_OWNADDR: hrdata <= {24'h000000, own_slave_address};
               default:          hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // bus outputs: open drain, only ever pull low
   // -----------------------------------------------------------------
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = gen_scl | wake_req | (serial_interrupt_flag & (state == S_WAIT | state == S_MSTR));
   assign sda_oe  = gen_sda | tx_bit_low | ack_low;
   // wake stays up until the flag goes
   assign wake_req = sleep_match & serial_interrupt_flag;

   // -----------------------------------------------------------------
   // main sequencer
   // -----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl              <= `TWS_RST_CTRL;
         own_slave_address <= `TWS_RST_OWNADDR;
         data              <= `TWS_RST_DATA;
         status            <= `TWS_RST_STATUS;
         presc             <= 2'b00;
         state             <= S_IDLE;
         gphase            <= G_IDLE;
         gcnt              <= 16'h0000;
         g_stop            <= 1'b0;
         g_start           <= 1'b0;
         gen_sda           <= 1'b0;
         gen_scl           <= 1'b0;
         shift             <= 8'h00;
         bitcnt            <= 4'h0;
         last_byte         <= 1'b0;
         master_ack        <= 1'b0;
         arb_pend          <= 1'b0;
         sleep_match       <= 1'b0;
         tx_bit_low        <= 1'b0;
         ack_low           <= 1'b0;
      end else begin
         // a clear lands first so that a same-cycle hardware set wins
         if (flag_clr) begin
            ctrl[`TWS_CTL_FLAG] <= 1'b0;
            sleep_match         <= 1'b0;
         end

         // software writes; the flag bit itself is handled above
         if (wr_pend) begin
            case (wr_addr)
               `TWS_OFS_CTRL: begin
                  ctrl[6:0] <= {hwdata[6:4], 1'b0, hwdata[2], 2'b00};
               end
               `TWS_OFS_STATUS:  presc <= hwdata[1:0];
               `TWS_OFS_DATA:    data <= hwdata[7:0];
               `TWS_OFS_OWNADDR: own_slave_address <= hwdata[7:0];
               default: ;
            endcase
         end

         if (arb_lost)
            arb_pend <= 1'b1;

         // slave side state machine
         case (state)
            S_IDLE: begin
               tx_bit_low <= 1'b0;
               ack_low    <= 1'b0;
               if (mr_nack_done) begin
                  data                <= mr_rx_byte;
                  status              <= `TWS_ST_MR_NACK;
                  ctrl[`TWS_CTL_FLAG] <= 1'b1;
                  state               <= S_MSTR;
               end else if (bus_start & interface_enable) begin
                  bitcnt <= 4'h0;
                  state  <= S_ADDR;
               end
            end
            S_ADDR: begin
               if (bus_stop) begin
                  state <= S_IDLE;
               end else if (bus_start) begin
                  bitcnt <= 4'h0;
               end else if (scl_rise) begin
                  shift  <= {shift[6:0], sda_s2};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall & bitcnt == 4'h8) begin
                  // no ack while acknowledge is off
                  // matching works in deep sleep too
                  if (acknowledge_enable & match_addr(shift[7:1], own_address_field, general_call_accept)) begin
                     ack_low     <= 1'b1;
                     sleep_match <= deep_sleep;
                     // sleep match does not update data
                     if (!deep_sleep)
                        data <= shift;
                     bitcnt <= 4'h0;
                     state  <= S_AACK;
                  end else begin
                     state <= S_IGN;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  ack_low             <= 1'b0;
                  ctrl[`TWS_CTL_FLAG] <= 1'b1;
                  // direction bit picks transmit or receive
                  if (shift[0]) begin
                     // flag and status on own read
                     status      <= arb_pend ? `TWS_ST_ARB_READ : `TWS_ST_OWN_READ;
                     arb_pend    <= 1'b0;
                     state       <= S_WAIT;
                  end else begin
                     // receive side lives elsewhere; report and step aside
                     status      <= (shift[7:1] == `TWS_GCALL_ADDR) ? `TWS_ST_SR_GCALL : `TWS_ST_SR_OWN;
                     state       <= S_IGN;
                  end
               end
            end
            S_WAIT: begin
               // byte loaded, flag cleared, ack enable read
               if (flag_clr) begin
                  shift      <= data;
                  last_byte  <= ~hwdata[`TWS_CTL_ACKEN];
                  tx_bit_low <= ~data[7];
                  bitcnt     <= 4'h1;
                  state      <= S_TX;
               end
            end
            S_TX: begin
               if (bus_stop | bus_start) begin
                  tx_bit_low <= 1'b0;
                  state      <= bus_start ? S_ADDR : S_IDLE;
                  bitcnt     <= 4'h0;
               end else if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     tx_bit_low <= 1'b0;
                     state      <= S_MACK;
                  end else begin
                     tx_bit_low <= ~shift[6];
                     shift      <= {shift[6:0], 1'b1};
                     bitcnt     <= bitcnt + 4'h1;
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  master_ack <= ~sda_s2;
               end else if (scl_fall) begin
                  ctrl[`TWS_CTL_FLAG] <= 1'b1;
                  if (!master_ack) begin
                     status      <= `TWS_ST_TX_NACK;
                     state       <= S_IGN;
                  end else if (last_byte) begin
                     // master wants more after the last byte
                     status      <= `TWS_ST_LAST_ACK;
                     state       <= S_IGN;
                  end else begin
                     status      <= `TWS_ST_TX_ACK;
                     state       <= S_WAIT;
                  end
               end
            end
            S_IGN: begin
               // master clocks in ones from here on
               tx_bit_low <= 1'b0;
               if (bus_stop) begin
                  state <= S_IDLE;
               end else if (bus_start & interface_enable) begin
                  bitcnt <= 4'h0;
                  state  <= S_ADDR;
               end
            end
            S_MSTR: begin
               if (flag_clr & gphase == G_IDLE) begin
                  g_stop  <= hwdata[`TWS_CTL_STOP];
                  g_start <= hwdata[`TWS_CTL_START];
                  if (hwdata[`TWS_CTL_STOP] | hwdata[`TWS_CTL_START]) begin
                     gphase  <= G_PREP;
                     gen_scl <= 1'b1;
                     gen_sda <= hwdata[`TWS_CTL_STOP];
                     gcnt    <= HALF;
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase

         // stop / start generation out of the 0x58 state
         if (gphase != G_IDLE) begin
            if (gcnt != 16'h0000) begin
               gcnt <= gcnt - 16'h0001;
            end else begin
               case (gphase)
                  G_PREP: begin
                     gen_scl <= 1'b0;
                     gcnt    <= HALF;
                     gphase  <= G_SCLHI;
                  end
                  G_SCLHI: begin
                     gcnt <= HALF;
                     if (g_stop) begin
                        // stop: data rises with clock high
                        gen_sda <= 1'b0;
                        gphase  <= G_STOP;
                     end else begin
                        gen_sda <= 1'b1;
                        gphase  <= G_START;
                     end
                  end
                  G_STOP: begin
                     ctrl[`TWS_CTL_STOP] <= 1'b0;
                     if (g_start) begin
                        gen_sda <= 1'b1;
                        gcnt    <= HALF;
                        gphase  <= G_START;
                     end else begin
                        gphase <= G_IDLE;
                        state  <= S_IDLE;
                     end
                  end
                  G_START: begin
                     ctrl[`TWS_CTL_STOP] <= 1'b0;
                     // data stays low and is let go a cycle later under a low clock,
                     // so both wires never move together and fake a stop
                     gen_scl             <= 1'b1;
                     gphase              <= G_IDLE;
                     ctrl[`TWS_CTL_FLAG] <= 1'b1;
                     status              <= g_stop ? `TWS_ST_START : `TWS_ST_RSTART;
                     state               <= S_IDLE;
                  end
                  default: gphase <= G_IDLE;
               endcase
            end
         end else if (state != S_MSTR) begin
            // clock taken on entry to 0x58, so the generator hand-over cannot glitch it high
            gen_scl <= (gen_scl & serial_interrupt_flag & ~flag_clr) | ((state == S_IDLE) & mr_nack_done);
            gen_sda <= gen_sda & ~gen_scl;
         end
      end
   end

endmodule

//--- testbench/tws_slave_tx_chk.sv
`timescale 1ns/1ns
module tws_slave_tx_chk (
   // clock and reset
   input logic        core_clk,
   input logic        reset_n,
   // register bus
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic        hreadyout,
   input logic        hresp,
   input logic [31:0] hrdata,
   // bus pins and sleep
   input logic        scl_out,
   input logic        scl_oe,
   input logic        sda_out,
   input logic        sda_oe,
   input logic        deep_sleep,
   input logic        wake_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire rd_req = hsel && hready && htrans[1] && !hwrite;

   ready_const_a: assert property (hreadyout)
      else $error("zero wait state slave stalled");
   resp_okay_a: assert property (!hresp)
      else $error("slave gave an error response");
   pins_low_a: assert property (!scl_out && !sda_out)
      else $error("open drain pin driven high");
   reset_quiet_a: assert property (disable iff (1'b0)
      !reset_n ##1 !reset_n |-> hrdata == 32'h0 && !scl_oe && !sda_oe && !wake_req)
      else $error("outputs not quiet in reset");
   read_upper_a: assert property (rd_req |=> hrdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   unmapped_zero_a: assert property (rd_req && haddr[7:0] > 8'h0c |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
      else $error("read data changed without a read");
   wake_hold_a: assert property (wake_req |-> scl_oe)
      else $error("clock released during wake");
   wake_cause_a: assert property ($rose(wake_req) |-> deep_sleep)
      else $error("wake request outside deep sleep");

   cover property ($rose(wake_req));
   cover property ($rose(sda_oe));
   cover property ($fell(scl_oe));
   cover property (rd_req ##1 !rd_req);
endmodule

bind tws_slave_tx tws_slave_tx_chk u_chk (
   .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
   .deep_sleep(deep_sleep), .wake_req(wake_req)
);

//--- testbench/tws_i2c_master.sv
`timescale 1ns/1ns
module tws_i2c_master #(
   parameter int HALF = 16
) (
   // bus wires
   input  logic scl,
   input  logic sda,
   // pull-down drives
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // one bit: set data in the low half, sample late in the high half
   task automatic bit_io(input logic bv, output logic sv);
      #7 sda_low = ~bv;
      #(HALF - 7) scl_low = 1'b0;
      wait (scl === 1'b1);
      #(HALF - 1) sv = sda;
      #1 scl_low = 1'b1;
   endtask
   task automatic start_cond;
      #7 sda_low = 1'b0;
      #(HALF - 7) scl_low = 1'b0;
      wait (scl === 1'b1);
      #HALF sda_low = 1'b1;
      #HALF scl_low = 1'b1;
   endtask
   task automatic stop_cond;
      #7 sda_low = 1'b1;
      #(HALF - 7) scl_low = 1'b0;
      wait (scl === 1'b1);
      #HALF sda_low = 1'b0;
      #HALF;
   endtask
   task automatic send_byte(input logic [7:0] bv, output logic ack);
      logic sv;
      for (int i = 7; i >= 0; i--) bit_io(bv[i], sv);
      bit_io(1'b1, sv);
      ack = ~sv;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] bv);
      logic sv;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, bv[i]);
      bit_io(~ack, sv);
   endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`include "tws_defines.vh"
module tb_top;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic        core_clk;
   logic        reset_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        deep_sleep;
   logic        arb_lost;
   logic        mr_nack_done;
   logic [7:0]  mr_rx_byte;
   wire         hready;
   wire         hresp;
   wire  [31:0] hrdata;
   wire         scl_out, scl_oe, sda_out, sda_oe, wake_req, m_scl_low, m_sda_low;
   // pull-ups: a released wire reads high
   wire         scl = !(scl_oe || m_scl_low);
   wire         sda = !(sda_oe || m_sda_low);
   int          errors, samples_checked, starts, stops;
   logic [31:0] r;
   logic        ack;
   logic [7:0]  b;
   localparam logic [31:0] a_ctrl = {24'h0, `TWS_OFS_CTRL};
   localparam logic [31:0] a_stat = {24'h0, `TWS_OFS_STATUS};
   localparam logic [31:0] a_data = {24'h0, `TWS_OFS_DATA};
   localparam logic [31:0] a_own  = {24'h0, `TWS_OFS_OWNADDR};

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(negedge sda) if (scl === 1'b1) starts++;
   always @(posedge sda) if (scl === 1'b1) stops++;

   tws_slave_tx DUT (
      .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .deep_sleep(deep_sleep),
      .arb_lost(arb_lost), .mr_nack_done(mr_nack_done), .mr_rx_byte(mr_rx_byte), .wake_req(wake_req));
   tws_i2c_master m (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task conclude;
      if (errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [31:0] a, input logic [7:0] d);
      xfer(a, 1'b1, {24'h0, d});
   endtask
   task rd(input logic [31:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 32'h0);
      check(r, {24'h0, e});
   endtask
   task rd_st(input logic [7:0] e);
      xfer(a_stat, 1'b0, 32'h0);
      check(r & 32'hf8, {24'h0, e});
   endtask
   task wait_flag;
      for (int i = 0; i < 4000; i++) begin
         xfer(a_ctrl, 1'b0, 32'h0);
         if (r[7] === 1'b1) break;
      end
      check({31'h0, r[7]}, 32'h1);
   endtask
   task addr_cycle(input logic [7:0] a, input logic e);
      m.start_cond;
      m.send_byte(a, ack);
      check({31'h0, ack}, {31'h0, e});
   endtask
   task own_read(input logic [7:0] st, input logic [7:0] d);
      addr_cycle(8'h55, 1'b1);
      wait_flag;
      rd_st(st);
      wr(a_data, d);
      wr(a_ctrl, 8'h84);
      m.recv_byte(1'b0, b);
      check({24'h0, b}, {24'h0, d});
      wait_flag;
      rd_st(`TWS_ST_TX_NACK);
      wr(a_ctrl, 8'hc4);
      m.stop_cond;
   endtask
   task do_reset;
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_regs;
      rd(a_ctrl, `TWS_RST_CTRL);
      rd(a_stat, `TWS_RST_STATUS);
      rd(a_data, `TWS_RST_DATA);
      rd(a_own, `TWS_RST_OWNADDR);
      wr(a_stat, 8'h03);
      rd_st(`TWS_RST_STATUS);
      wr(32'h10, 8'h77);
      rd(32'h10, 8'h00);
      wr(a_ctrl, 8'h4f);
      rd(a_ctrl, 8'h44);
      wr(a_own, 8'h55);
      rd(a_own, 8'h55);
      wr(a_ctrl, 8'h44);
   endtask
   task t_stream;
      addr_cycle(8'h55, 1'b1);
      wait_flag;
      rd_st(`TWS_ST_OWN_READ);
      wr(a_data, 8'ha5);
      wr(a_ctrl, 8'hc4);
      m.recv_byte(1'b1, b);
      check({24'h0, b}, 32'ha5);
      wait_flag;
      rd_st(`TWS_ST_TX_ACK);
      wr(a_data, 8'h3c);
      wr(a_ctrl, 8'h84);
      m.recv_byte(1'b1, b);
      check({24'h0, b}, 32'h3c);
      wait_flag;
      rd_st(`TWS_ST_LAST_ACK);
      wr(a_ctrl, 8'hc4);
      m.recv_byte(1'b0, b);
      check({24'h0, b}, 32'hff);
      m.stop_cond;
   endtask
   task t_refuse;
      addr_cycle(8'h00, 1'b1);
      wait_flag;
      rd_st(`TWS_ST_SR_GCALL);
      wr(a_ctrl, 8'hc4);
      m.stop_cond;
      wr(a_own, 8'h54);
      addr_cycle(8'h00, 1'b0);
      m.stop_cond;
      addr_cycle(8'h57, 1'b0);
      m.stop_cond;
      wr(a_ctrl, 8'h04);
      addr_cycle(8'h54, 1'b0);
      m.stop_cond;
      wr(a_ctrl, 8'h44);
      own_read(`TWS_ST_OWN_READ, 8'h5a);
   endtask
   task t_arb;
      @(posedge core_clk);
      arb_lost <= 1'b1;
      @(posedge core_clk);
      arb_lost <= 1'b0;
      own_read(`TWS_ST_ARB_READ, 8'h81);
   endtask
   task t_sleep;
      @(posedge core_clk);
      deep_sleep <= 1'b1;
      addr_cycle(8'h55, 1'b1);
      wait_flag;
      check({31'h0, wake_req}, 32'h1);
      check({31'h0, scl_oe}, 32'h1);
      rd_st(`TWS_ST_OWN_READ);
      wr(a_ctrl, 8'h84);
      repeat (2) @(negedge core_clk);
      check({31'h0, wake_req}, 32'h0);
      check({31'h0, scl_oe}, 32'h0);
      // byte content is left unchecked after a sleep match
      m.recv_byte(1'b0, b);
      wait_flag;
      rd_st(`TWS_ST_TX_NACK);
      wr(a_ctrl, 8'hc4);
      m.stop_cond;
      @(posedge core_clk);
      deep_sleep <= 1'b0;
   endtask
   task gen(input logic [7:0] ctl, input logic [7:0] st, input int n_start, input int n_stop);
      int s0;
      int p0;
      @(posedge core_clk);
      mr_rx_byte <= 8'h6b;
      mr_nack_done <= 1'b1;
      @(posedge core_clk);
      mr_nack_done <= 1'b0;
      wait_flag;
      rd_st(`TWS_ST_MR_NACK);
      rd(a_data, 8'h6b);
      s0 = starts;
      p0 = stops;
      wr(a_ctrl, ctl);
      // four generation steps of 1251 cycles each take 5004 cycles
      repeat (6000) @(posedge core_clk);
      check(32'(starts - s0), 32'(n_start));
      check(32'(stops - p0), 32'(n_stop));
      if (st == 8'h00) begin
         rd(a_ctrl, 8'h44);
      end else begin
         wait_flag;
         rd_st(st);
      end
   endtask

   initial begin
      reset_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      deep_sleep = 1'b0;
      arb_lost = 1'b0;
      mr_nack_done = 1'b0;
      mr_rx_byte = 8'h00;
      do_reset;
      t_regs;
      t_stream;
      t_refuse;
      t_arb;
      t_sleep;
      gen(8'hd4, 8'h00, 0, 1);
      gen(8'hf4, `TWS_ST_START, 1, 1);
      do_reset;
      wr(a_ctrl, 8'h44);
      gen(8'he4, `TWS_ST_RSTART, 1, 0);
      conclude;
   end
   initial begin
      #300000;
      errors++;
      conclude;
   end
endmodule
